// ### inc/lac_pkg.sv
// package for the logic analyzer capture control block
package lac_pkg;
   // register byte offsets
   localparam logic [7:0] LAC_CTRL_OFF = 8'h00;
   localparam logic [7:0] LAC_CFG_OFF = 8'h04;
   localparam logic [7:0] LAC_STAT_OFF = 8'h08;
   localparam logic [7:0] LAC_WIN_OFF = 8'h0c;
   localparam logic [7:0] LAC_TOTAL_OFF = 8'h10;
   localparam logic [7:0] LAC_IRQ_STAT_OFF = 8'h14;
   localparam logic [7:0] LAC_IRQ_MASK_OFF = 8'h18;
   // ctrl bits (write one pulses)
   localparam int LAC_CTRL_ARM = 0;
   localparam int LAC_CTRL_ARM_IMM = 1;
   localparam int LAC_CTRL_STOP = 2;
   localparam int LAC_CTRL_UPLOAD_DONE = 3;
   // cfg fields
   localparam int LAC_CFG_TPOS_LSB = 0;
   localparam int LAC_CFG_NWIN_LSB = 12;
   localparam int LAC_CFG_CAPMODE = 16;
   localparam int LAC_CFG_ADVMODE = 17;
   localparam int LAC_CFG_DEPTH_LSB = 20;
   localparam logic [31:0] LAC_CFG_RST = 32'h0000_0000;
   // widths
   localparam int LAC_SW = 10;
   localparam int LAC_WW = 4;
   localparam int LAC_TW = 16;
   localparam int LAC_FSM_W = 4;
   localparam int LAC_NFLAGS = 4;
   // interrupt bits
   localparam int LAC_IRQ_TRIG = 0;
   localparam int LAC_IRQ_WIN = 1;
   localparam int LAC_IRQ_FULL = 2;
   localparam int LAC_IRQ_HALT = 3;
   localparam int LAC_IRQ_W = 4;

   typedef enum logic [2:0] {
      LAC_ST_IDLE,
      LAC_ST_PRE,
      LAC_ST_WAIT,
      LAC_ST_POST,
      LAC_ST_FULL
   } lac_state_t;

   typedef struct packed {
      logic [LAC_SW-1:0] tpos;
      logic [LAC_WW-1:0] nwin_m1;
      logic [3:0] depth_log2;
      logic capture_basic;
      logic adv_mode;
   } lac_cfg_t;

   typedef struct packed {
      logic [LAC_WW-1:0] win;
      logic [LAC_SW:0] wcnt;
      logic [LAC_TW-1:0] total;
   } lac_cnt_t;
endpackage : lac_pkg

// ### hw/lac_apb_slave.sv
// apb slave front end producing access strobes
`timescale 1ns/100ps
`default_nettype none
module lac_apb_slave
   import lac_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   // strobes
   output logic wr_o,
   output logic rd_o,
   output logic ready_o
);
   logic acc_d;
   logic acc_q;

   always_comb begin
      acc_d = psel_i && penable_i && !acc_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
      end
   end

   // one wait state: answer one cycle into the access phase
   assign ready_o = acc_q;
   assign wr_o = acc_q && psel_i && penable_i && pwrite_i;
   assign rd_o = acc_q && psel_i && penable_i && !pwrite_i;
endmodule : lac_apb_slave
`default_nettype wire

// ### hw/lac_capture_ctrl.sv
// trigger and capture sequencing engine with apb registers
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module lac_capture_ctrl
   import lac_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // apb
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // trigger engine
   input wire logic TRIG_EVENT_I,
   input wire logic CAP_COND_I,
   input wire logic [LAC_NFLAGS-1:0] TSM_FLAGS_I,
   input wire logic [LAC_FSM_W-1:0] TSM_STATE_I,
   // sample buffer write
   output logic SAMPLE_WE_O,
   output logic [LAC_WW+LAC_SW-1:0] SAMPLE_ADDR_O,
   // status
   output logic [LAC_WW:0] VALID_WINS_O,
   output logic IRQ_O
);
   logic wr;
   logic rd;
   logic rdy;

   lac_apb_slave u_apb (
      .clk_i(CLK_SYS_I),
      .rst_i(RST_I),
      .psel_i(PSEL_I),
      .penable_i(PENABLE_I),
      .pwrite_i(PWRITE_I),
      .paddr_i(PADDR_I),
      .wr_o(wr),
      .rd_o(rd),
      .ready_o(rdy)
   );

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, LAC_CTRL_OFF) || hit(a, LAC_CFG_OFF) || hit(a, LAC_STAT_OFF) ||
               hit(a, LAC_WIN_OFF) || hit(a, LAC_TOTAL_OFF) || hit(a, LAC_IRQ_STAT_OFF) ||
               hit(a, LAC_IRQ_MASK_OFF);
   endfunction : mapped

   // command pulses
   logic arm_c;
   logic imm_c;
   logic stop_c;
   logic upl_c;
   always_comb begin
      arm_c = wr && hit(PADDR_I, LAC_CTRL_OFF) && PWDATA_I[LAC_CTRL_ARM];
      imm_c = wr && hit(PADDR_I, LAC_CTRL_OFF) && PWDATA_I[LAC_CTRL_ARM_IMM];
      stop_c = wr && hit(PADDR_I, LAC_CTRL_OFF) && PWDATA_I[LAC_CTRL_STOP];
      upl_c = wr && hit(PADDR_I, LAC_CTRL_OFF) && PWDATA_I[LAC_CTRL_UPLOAD_DONE];
   end

   // configuration and mask registers
   lac_cfg_t cfg_q;
   lac_cfg_t cfg_d;
   logic [LAC_IRQ_W-1:0] mask_q;
   logic [LAC_IRQ_W-1:0] mask_d;
   always_comb begin
      cfg_d = cfg_q;
      mask_d = mask_q;
      if (wr && hit(PADDR_I, LAC_CFG_OFF)) begin
         cfg_d.tpos = PWDATA_I[LAC_CFG_TPOS_LSB +: LAC_SW];
         cfg_d.nwin_m1 = PWDATA_I[LAC_CFG_NWIN_LSB +: LAC_WW];
         cfg_d.capture_basic = PWDATA_I[LAC_CFG_CAPMODE];
         cfg_d.adv_mode = PWDATA_I[LAC_CFG_ADVMODE];
         cfg_d.depth_log2 = (PWDATA_I[LAC_CFG_DEPTH_LSB +: 4] > 4'(LAC_SW)) ? 4'(LAC_SW)
                            : PWDATA_I[LAC_CFG_DEPTH_LSB +: 4];
      end
      if (wr && hit(PADDR_I, LAC_IRQ_MASK_OFF)) begin
         mask_d = PWDATA_I[LAC_IRQ_W-1:0];
      end
   end

   // capture sequencer
   lac_state_t st_q;
   lac_state_t st_d;
   lac_cnt_t cnt_q;
   lac_cnt_t cnt_d;
   logic imm_q;
   logic imm_d;
   logic trig_in_win_q;
   logic trig_in_win_d;
   logic [LAC_WW:0] vwin_q;
   logic [LAC_WW:0] vwin_d;
   logic [LAC_IRQ_W-1:0] ev;
   logic [LAC_SW:0] depth;
   logic store;
   logic trig;
   logic last_smp;

   always_comb begin
      depth = (LAC_SW+1)'(1) << cfg_q.depth_log2;
      // sampling qualified by capture mode
      store = !cfg_q.capture_basic || CAP_COND_I;
      trig = TRIG_EVENT_I || imm_q;
      last_smp = store && (cnt_q.wcnt == depth - (LAC_SW+1)'(1));
      st_d = st_q;
      cnt_d = cnt_q;
      imm_d = imm_q;
      trig_in_win_d = trig_in_win_q;
      vwin_d = vwin_q;
      ev = '0;
      case (st_q)
         LAC_ST_IDLE: begin
            cnt_d = '0;
            vwin_d = '0;
            trig_in_win_d = 1'b0;
            if (arm_c || imm_c) begin
               imm_d = imm_c;
               st_d = (cfg_q.tpos == '0) ? LAC_ST_WAIT : LAC_ST_PRE;
            end
         end
         LAC_ST_PRE: begin
            if (store) begin
               cnt_d.wcnt = cnt_q.wcnt + (LAC_SW+1)'(1);
               cnt_d.total = cnt_q.total + LAC_TW'(1);
               if (cnt_q.wcnt + (LAC_SW+1)'(1) >= {1'b0, cfg_q.tpos}) begin
                  st_d = LAC_ST_WAIT;
               end
            end
         end
         LAC_ST_WAIT: begin
            // trigger sample is stored only if store is high; pre-trigger samples stay put, the slot at the mark is rewritten while waiting
            if (trig) begin
               ev[LAC_IRQ_TRIG] = 1'b1;
               trig_in_win_d = 1'b1;
               imm_d = 1'b0;
               cnt_d.wcnt = {1'b0, cfg_q.tpos} + (LAC_SW+1)'(1);
               cnt_d.total = cnt_q.total + LAC_TW'(1);
               st_d = LAC_ST_POST;
               if ({1'b0, cfg_q.tpos} >= depth - (LAC_SW+1)'(1)) begin
                  // mark is the last sample: the window completes with the trigger
                  ev[LAC_IRQ_WIN] = 1'b1;
                  vwin_d = vwin_q + (LAC_WW+1)'(1);
                  trig_in_win_d = 1'b0;
                  if (cnt_q.win == cfg_q.nwin_m1) begin
                     st_d = LAC_ST_FULL;
                     ev[LAC_IRQ_FULL] = 1'b1;
                  end else begin
                     cnt_d.win = cnt_q.win + LAC_WW'(1);
                     cnt_d.wcnt = '0;
                     st_d = (cfg_q.tpos == '0) ? LAC_ST_WAIT : LAC_ST_PRE;
                  end
               end
            end
         end
         LAC_ST_POST: begin
            if (cnt_q.wcnt >= depth || last_smp) begin
               ev[LAC_IRQ_WIN] = 1'b1;
               vwin_d = vwin_q + (LAC_WW+1)'(1);
               trig_in_win_d = 1'b0;
               if (last_smp) begin
                  cnt_d.total = cnt_q.total + LAC_TW'(1);
               end
               if (cnt_q.win == cfg_q.nwin_m1) begin
                  st_d = LAC_ST_FULL;
                  ev[LAC_IRQ_FULL] = 1'b1;
               end else begin
                  // next window armed on the very next cycle
                  cnt_d.win = cnt_q.win + LAC_WW'(1);
                  cnt_d.wcnt = '0;
                  st_d = (cfg_q.tpos == '0) ? LAC_ST_WAIT : LAC_ST_PRE;
               end
            end else if (store) begin
               cnt_d.wcnt = cnt_q.wcnt + (LAC_SW+1)'(1);
               cnt_d.total = cnt_q.total + LAC_TW'(1);
            end
         end
         LAC_ST_FULL: begin
            // buffer frozen, triggers ignored until upload done
            if (upl_c) begin
               st_d = LAC_ST_IDLE;
            end
         end
         default: begin
            st_d = LAC_ST_IDLE;
         end
      endcase
      if (stop_c && st_q != LAC_ST_IDLE && st_q != LAC_ST_FULL) begin
         // a window completed this cycle is already counted in vwin_d
         vwin_d = vwin_d + (LAC_WW+1)'(trig_in_win_d);
         st_d = LAC_ST_FULL;
         ev[LAC_IRQ_HALT] = 1'b1;
      end
   end

   logic capturing;
   always_comb begin
      capturing = store && (st_q == LAC_ST_PRE || st_q == LAC_ST_WAIT ||
                  (st_q == LAC_ST_POST && cnt_q.wcnt < depth));
   end

   // interrupt status: set beats clear-on-read
   logic [LAC_IRQ_W-1:0] irq_q;
   logic [LAC_IRQ_W-1:0] irq_d;
   always_comb begin
      irq_d = irq_q;
      if (rd && hit(PADDR_I, LAC_IRQ_STAT_OFF)) begin
         // clear only the bits the host was shown, so a later event survives
         irq_d = irq_q & ~PRDATA_O[LAC_IRQ_W-1:0];
      end
      irq_d = irq_d | ev;
   end

   // read mux
   logic [31:0] rdata_d;
   logic [LAC_FSM_W-1:0] tstate;
   always_comb begin
      tstate = (cfg_q.adv_mode && st_q == LAC_ST_WAIT) ? TSM_STATE_I : '0;
      rdata_d = '0;
      if (hit(PADDR_I, LAC_CFG_OFF)) begin
         rdata_d[LAC_CFG_TPOS_LSB +: LAC_SW] = cfg_q.tpos;
         rdata_d[LAC_CFG_NWIN_LSB +: LAC_WW] = cfg_q.nwin_m1;
         rdata_d[LAC_CFG_CAPMODE] = cfg_q.capture_basic;
         rdata_d[LAC_CFG_ADVMODE] = cfg_q.adv_mode;
         rdata_d[LAC_CFG_DEPTH_LSB +: 4] = cfg_q.depth_log2;
      end else if (hit(PADDR_I, LAC_STAT_OFF)) begin
         rdata_d[2:0] = st_q;
         rdata_d[7:4] = cfg_q.adv_mode ? TSM_FLAGS_I : '0;
         rdata_d[11:8] = tstate;
         rdata_d[12 +: LAC_WW+1] = vwin_q;
      end else if (hit(PADDR_I, LAC_WIN_OFF)) begin
         rdata_d[LAC_SW:0] = cnt_q.wcnt;
         rdata_d[16 +: LAC_WW] = cnt_q.win;
      end else if (hit(PADDR_I, LAC_TOTAL_OFF)) begin
         rdata_d[LAC_TW-1:0] = cnt_q.total;
      end else if (hit(PADDR_I, LAC_IRQ_STAT_OFF)) begin
         rdata_d[LAC_IRQ_W-1:0] = irq_q;
      end else if (hit(PADDR_I, LAC_IRQ_MASK_OFF)) begin
         rdata_d[LAC_IRQ_W-1:0] = mask_q;
      end
   end

   logic we_d;
   logic [LAC_WW+LAC_SW-1:0] addr_d;
   always_comb begin
      we_d = capturing;
      addr_d = {cnt_q.win, cnt_q.wcnt[LAC_SW-1:0]};
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         cfg_q <= LAC_CFG_RST[$bits(lac_cfg_t)-1:0];
         mask_q <= '0;
         st_q <= LAC_ST_IDLE;
         cnt_q <= '0;
         imm_q <= 1'b0;
         trig_in_win_q <= 1'b0;
         vwin_q <= '0;
         irq_q <= '0;
         PRDATA_O <= '0;
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         SAMPLE_WE_O <= 1'b0;
         SAMPLE_ADDR_O <= '0;
         VALID_WINS_O <= '0;
         IRQ_O <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         mask_q <= mask_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         imm_q <= imm_d;
         trig_in_win_q <= trig_in_win_d;
         vwin_q <= vwin_d;
         irq_q <= irq_d;
         PRDATA_O <= rdata_d;
         PREADY_O <= PSEL_I && PENABLE_I && !rdy && !PREADY_O;
         PSLVERR_O <= PSEL_I && PENABLE_I && !rdy && !PREADY_O && !mapped(PADDR_I);
         SAMPLE_WE_O <= we_d;
         SAMPLE_ADDR_O <= addr_d;
         VALID_WINS_O <= vwin_d;
         IRQ_O <= |(irq_d & mask_d);
      end
   end
endmodule : lac_capture_ctrl
`default_nettype wire

// ### dv/lac_capture_ctrl_checker.sv
// port assertions for the capture control block
`timescale 1ns/100ps
`default_nettype none
module lac_capture_ctrl_checker
   import lac_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire logic [LAC_WW:0] VALID_WINS_O,
   input wire logic IRQ_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   sequence s_access;
      PSEL_I && PENABLE_I && !$past(PENABLE_I);
   endsequence
   chk_ready_wait: assert property (s_access |=> PREADY_O) else $error("ready late");
   chk_ready_single: assert property (PREADY_O |=> !PREADY_O) else $error("ready stuck");
   chk_ready_cause: assert property (PREADY_O |-> PSEL_I && PENABLE_I) else $error("ready unasked");
   chk_err_ready: assert property (PSLVERR_O |-> PREADY_O) else $error("error alone");
   chk_unmapped_zero: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == '0) else $error("bad data");
   chk_reset_clear: assert property (disable iff (1'b0) RST_I |=> VALID_WINS_O == '0 && !IRQ_O)
      else $error("reset values");
   chk_valid_step: assert property ($changed(VALID_WINS_O) |-> VALID_WINS_O == '0 ||
      VALID_WINS_O == $past(VALID_WINS_O) + 1'b1) else $error("window count jump");
   chk_irq_fall: assert property ($fell(IRQ_O) |-> $past(PREADY_O)) else $error("irq dropped");
endmodule : lac_capture_ctrl_checker
bind lac_capture_ctrl lac_capture_ctrl_checker u_chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .VALID_WINS_O(VALID_WINS_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ### dv/lac_host_model.sv
// apb master standing in for the host debug software
`timescale 1ns/100ps
`default_nettype none
module lac_host_model
   import lac_pkg::*;
(
   input wire logic clk_i,
   input wire logic pready_i,
   input wire logic pslverr_i,
   input wire logic [31:0] prdata_i,
   output logic psel_o = 1'b0,
   output logic penable_o = 1'b0,
   output logic pwrite_o = 1'b0,
   output logic [7:0] paddr_o = 8'h00,
   output logic [31:0] pwdata_o = 32'h0
);
   int to_cnt = 0;
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
      output logic err);
      int n;
      @(posedge clk_i);
      psel_o <= 1'b1;
      pwrite_o <= wr;
      paddr_o <= a;
      pwdata_o <= wd;
      @(posedge clk_i);
      penable_o <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_i !== 1'b1 && n < 16);
      if (n >= 16) to_cnt++;
      rd = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // released bus shows no stale value
      paddr_o <= ~a;
      pwdata_o <= ~wd;
   endtask : xfer
   // upload finished, then arm again over the old capture
   task rearm(input logic imm);
      logic [31:0] d;
      logic e;
      xfer(1'b1, LAC_CTRL_OFF, 32'h8, d, e);
      xfer(1'b1, LAC_CTRL_OFF, imm ? 32'h2 : 32'h1, d, e);
   endtask : rearm
endmodule : lac_host_model
`default_nettype wire

// ### dv/lac_capture_ctrl_tb.sv
// self-checking testbench for the capture control block
`timescale 1ns/100ps
`default_nettype none
module lac_capture_ctrl_tb;
   import lac_pkg::*;
   logic clk = 0, rst = 1, trig = 0, cond = 0, psel, pen, pwr, pready, perr, we, irq, err;
   logic [3:0] flags = '0, tst = '0;
   logic [7:0] paddr;
   logic [31:0] pwd, prd, d;
   logic [13:0] saddr;
   logic [13:0] last_addr = '0;
   logic [4:0] vw;
   int n_fail = 0, compares = 0, we_cnt = 0, run = 0, maxrun = 0, w0 = 0;
   initial forever #20 clk = ~clk;
   always @(posedge clk) begin
      we_cnt <= we_cnt + (we === 1'b1);
      run <= (we === 1'b1) ? run + 1 : 0;
      if (we === 1'b1) last_addr <= saddr;
      if (run > maxrun) maxrun <= run;
   end
   lac_capture_ctrl dut (.CLK_SYS_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr),
      .TRIG_EVENT_I(trig), .CAP_COND_I(cond), .TSM_FLAGS_I(flags), .TSM_STATE_I(tst),
      .SAMPLE_WE_O(we), .SAMPLE_ADDR_O(saddr), .VALID_WINS_O(vw), .IRQ_O(irq));
   lac_host_model host (.clk_i(clk), .pready_i(pready), .pslverr_i(perr), .prdata_i(prd),
      .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwd));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wrap_up;
      n_fail += host.to_cnt;
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task wr(input logic [7:0] a, input logic [31:0] v);
      host.xfer(1'b1, a, v, d, err);
   endtask : wr
   task rd(input logic [7:0] a);
      host.xfer(1'b0, a, 32'h0, d, err);
   endtask : rd
   task wait_st(input logic [2:0] s);
      for (int i = 0; i < 100; i++) begin
         rd(LAC_STAT_OFF);
         if (d[2:0] === s) return;
      end
      n_fail++;
      wrap_up;
   endtask : wait_st
   function automatic logic [31:0] cfg(logic [9:0] tp, logic [3:0] nwm1, logic [3:0] dl, logic bas, logic adv);
      return {8'h00, dl, 2'b00, adv, bas, nwm1, 2'b00, tp};
   endfunction : cfg
   function automatic logic [31:0] stat(logic [2:0] s, logic [3:0] fl, logic [3:0] ts, logic [4:0] v);
      return {15'h0000, v, ts, fl, 1'b0, s};
   endfunction : stat
   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      wrap_up;
   end
   initial begin
      void'($urandom(32));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(LAC_CFG_OFF);
      chk("cfg reset", d, LAC_CFG_RST);
      rd(LAC_STAT_OFF);
      chk("status reset", d, 32'h0);
      rd(8'h1c);
      chk("unmapped read", {d[30:0], err}, 32'h1);
      wr(LAC_IRQ_MASK_OFF, 32'hf);
      wr(LAC_CFG_OFF, cfg(10'h0, 4'h0, 4'h2, 1'b0, 1'b0));
      wr(LAC_CTRL_OFF, 32'h1);
      rd(LAC_STAT_OFF);
      chk("armed at mark zero", d, stat(3'h2, 4'h0, 4'h0, 5'h0));
      trig <= 1'b1;
      wait_st(LAC_ST_FULL);
      trig <= 1'b0;
      rd(LAC_TOTAL_OFF);
      chk("total one window", d, 32'h4);
      chk("irq raised", irq, 1'b1);
      rd(LAC_IRQ_STAT_OFF);
      chk("irq status", d, 32'h7);
      rd(LAC_IRQ_STAT_OFF);
      chk("irq cleared", irq, 1'b0);
      w0 = we_cnt;
      trig <= 1'b1;
      repeat (10) @(posedge clk);
      trig <= 1'b0;
      chk("no capture while full", we_cnt - w0, 0);
      host.rearm(1'b0);
      rd(LAC_STAT_OFF);
      chk("re-armed", d[2:0], LAC_ST_WAIT);
      wr(LAC_CTRL_OFF, 32'h4);
      wait_st(LAC_ST_FULL);
      chk("stop without trigger", vw, 5'h0);
      wr(LAC_CFG_OFF, cfg(10'h2, 4'h0, 4'h2, 1'b1, 1'b0));
      wr(LAC_CTRL_OFF, 32'h8);
      rd(LAC_WIN_OFF);
      chk("window cleared", d, 32'h0);
      rd(LAC_TOTAL_OFF);
      chk("total cleared", d, 32'h0);
      wr(LAC_CTRL_OFF, 32'h1);
      repeat (10) @(posedge clk);
      rd(LAC_STAT_OFF);
      chk("pre held by condition", d[2:0], LAC_ST_PRE);
      cond <= 1'b1;
      wait_st(LAC_ST_WAIT);
      cond <= 1'b0;
      trig <= 1'b1;
      wait_st(LAC_ST_POST);
      trig <= 1'b0;
      wr(LAC_CTRL_OFF, 32'h4);
      wait_st(LAC_ST_FULL);
      chk("partial window kept", vw, 5'h1);
      wr(LAC_CFG_OFF, cfg(10'h0, 4'h0, 4'h2, 1'b0, 1'b0));
      host.rearm(1'b1);
      wait_st(LAC_ST_FULL);
      rd(LAC_TOTAL_OFF);
      chk("immediate total", d, 32'h4);
      wr(LAC_CFG_OFF, cfg(10'h0, 4'h1, 4'h2, 1'b0, 1'b0));
      wr(LAC_CTRL_OFF, 32'h8);
      maxrun = 0;
      trig <= 1'b1;
      wr(LAC_CTRL_OFF, 32'h1);
      wait_st(LAC_ST_FULL);
      trig <= 1'b0;
      chk("windows back to back", maxrun, 8);
      chk("last sample address", last_addr, 14'h0403);
      chk("two windows valid", vw, 5'h2);
      wr(LAC_CFG_OFF, cfg(10'h0, 4'h0, 4'h2, 1'b0, 1'b1));
      wr(LAC_CTRL_OFF, 32'h8);
      wr(LAC_CTRL_OFF, 32'h1);
      for (int i = 0; i < 4; i++) begin
         flags <= 4'($urandom);
         tst <= 4'($urandom);
         rd(LAC_STAT_OFF);
         chk("advanced status", d, stat(3'h2, flags, tst, 5'h0));
      end
      rd(LAC_IRQ_STAT_OFF);
      wr(LAC_IRQ_MASK_OFF, 32'h0);
      wr(LAC_CTRL_OFF, 32'h4);
      wait_st(LAC_ST_FULL);
      chk("full hides trigger state", d, stat(3'h4, flags, 4'h0, 5'h0));
      chk("irq masked", irq, 1'b0);
      rd(LAC_IRQ_STAT_OFF);
      chk("stop event", d, 32'h8);
      wrap_up;
   end
endmodule : lac_capture_ctrl_tb
`default_nettype wire
